// file: rdi_pkg.sv
// Constants for the transmit path RDI-P automatic insertion block
package rdi_pkg;
    // Register addresses on the 16-bit host address bus
    localparam logic [15:0] ADDR_CELL_AND_LABEL       = 16'h19C9;
    localparam logic [15:0] ADDR_TRACE_AND_UNEQUIPPED = 16'h19CA;
    localparam logic [15:0] ADDR_POINTER_AND_ALARM    = 16'h19CB;
    localparam logic [15:0] ADDR_PATH_CTRL            = 16'h1983;

    // Field positions shared by all three code registers
    localparam int HI_CODE_MSB = 7;
    localparam int HI_CODE_LSB = 5;
    localparam int HI_EN_BIT   = 4;
    localparam int LO_CODE_MSB = 3;
    localparam int LO_CODE_LSB = 1;
    localparam int LO_EN_BIT   = 0;

    // Insertion type field inside the path control register
    localparam int SRC_SEL_MSB = 4;
    localparam int SRC_SEL_LSB = 3;
    localparam logic [1:0] SRC_SEL_AUTO = 2'h0;

    // RDI-P field position inside G1
    localparam int G1_RDI_MSB = 7;
    localparam int G1_RDI_LSB = 5;

    // Reset values
    localparam logic [7:0] RESET_CODE_REG  = 8'h00;
    localparam logic [7:0] RESET_PATH_CTRL = 8'h00;
    localparam logic [2:0] RDI_NONE        = 3'h0;

    // Defect indices, highest priority first
    localparam int DEF_COUNT = 6;
    localparam int DEF_AIS   = 0;
    localparam int DEF_LOP   = 1;
    localparam int DEF_UNEQ  = 2;
    localparam int DEF_TIM   = 3;
    localparam int DEF_PLM   = 4;
    localparam int DEF_LCD   = 5;
endpackage

// file: rdi_select.sv
// Fixed-priority picker of the RDI-P code among declared defects
`timescale 1ns/1ps
module rdi_select (
    // Per-defect qualifiers and codes, index 0 has top priority
    input  wire logic [5:0] active_i,
    input  wire logic [17:0] codes_i,
    // Chosen code
    output logic [2:0]       code_o
);
    import rdi_pkg::*;

    // Walk from lowest to highest priority so the highest wins
    always_comb begin
        code_o = RDI_NONE;
        for (int k = DEF_COUNT - 1; k >= 0; k--) begin
            if (active_i[k]) begin
                code_o = codes_i[3*k +: 3];
            end
        end
    end
endmodule

// file: tx_path_rdi_auto_insertion.sv
// Transmit path G1 RDI-P automatic insertion with host control registers
`timescale 1ns/1ps
module tx_path_rdi_auto_insertion (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RSTN_I,
    // Host register port
    input  wire logic [15:0] ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    // Defect declarations from the receive path processor
    input  wire logic        PATH_ALARM_I,
    input  wire logic        POINTER_LOSS_I,
    input  wire logic        UNEQUIPPED_I,
    input  wire logic        TRACE_MISMATCH_I,
    input  wire logic        LABEL_MISMATCH_I,
    input  wire logic        CELL_DELINEATION_LOSS_I,
    // Outbound byte stream
    input  wire logic [7:0]  TX_DATA_I,
    input  wire logic        TX_G1_I,
    output logic      [7:0]  TX_DATA_O,
    output logic             TX_G1_O,
    output logic      [2:0]  RDI_CODE_O
);
    import rdi_pkg::*;

    logic [7:0] rdi_ctrl_cell_and_label;
    logic [7:0] rdi_ctrl_trace_and_unequipped;
    logic [7:0] rdi_ctrl_pointer_and_alarm;
    logic [7:0] path_ctrl;
    logic [5:0] defect_meta;
    logic [5:0] defect_sync;
    logic [5:0] enables;
    logic [17:0] codes;
    logic [5:0] active;
    logic [2:0] chosen;
    logic       auto_mode;

    // Code and path control register writes; the host bus is on this clock
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            rdi_ctrl_cell_and_label       <= RESET_CODE_REG;
            rdi_ctrl_trace_and_unequipped <= RESET_CODE_REG;
            rdi_ctrl_pointer_and_alarm    <= RESET_CODE_REG;
            path_ctrl                     <= RESET_PATH_CTRL;
        end else if (WR_I) begin
            case (ADDR_I)
                ADDR_CELL_AND_LABEL:
                    rdi_ctrl_cell_and_label <= WDATA_I;
                ADDR_TRACE_AND_UNEQUIPPED:
                    rdi_ctrl_trace_and_unequipped <= WDATA_I;
                ADDR_POINTER_AND_ALARM:
                    rdi_ctrl_pointer_and_alarm <= WDATA_I;
                ADDR_PATH_CTRL:
                    path_ctrl <= WDATA_I;
                default: ;
            endcase
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            case (ADDR_I)
                ADDR_CELL_AND_LABEL:       RDATA_O <= rdi_ctrl_cell_and_label;
                ADDR_TRACE_AND_UNEQUIPPED:
                    RDATA_O <= rdi_ctrl_trace_and_unequipped;
                ADDR_POINTER_AND_ALARM:
                    RDATA_O <= rdi_ctrl_pointer_and_alarm;
                ADDR_PATH_CTRL:            RDATA_O <= path_ctrl;
                default:                   RDATA_O <= 8'h00;
            endcase
        end
    end

    // Defects come from another block's timing, so double-register them
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            defect_meta <= 6'h00;
            defect_sync <= 6'h00;
        end else begin
            defect_meta <= {CELL_DELINEATION_LOSS_I, LABEL_MISMATCH_I,
                            TRACE_MISMATCH_I, UNEQUIPPED_I,
                            POINTER_LOSS_I, PATH_ALARM_I};
            defect_sync <= defect_meta;
        end
    end

    // Gather enables and codes in priority order
    assign enables = {rdi_ctrl_cell_and_label[HI_EN_BIT],
                      rdi_ctrl_cell_and_label[LO_EN_BIT],
                      rdi_ctrl_trace_and_unequipped[HI_EN_BIT],
                      rdi_ctrl_trace_and_unequipped[LO_EN_BIT],
                      rdi_ctrl_pointer_and_alarm[HI_EN_BIT],
                      rdi_ctrl_pointer_and_alarm[LO_EN_BIT]};
    assign codes = {
        rdi_ctrl_cell_and_label[HI_CODE_MSB:HI_CODE_LSB],
        rdi_ctrl_cell_and_label[LO_CODE_MSB:LO_CODE_LSB],
        rdi_ctrl_trace_and_unequipped[HI_CODE_MSB:HI_CODE_LSB],
        rdi_ctrl_trace_and_unequipped[LO_CODE_MSB:LO_CODE_LSB],
        rdi_ctrl_pointer_and_alarm[HI_CODE_MSB:HI_CODE_LSB],
        rdi_ctrl_pointer_and_alarm[LO_CODE_MSB:LO_CODE_LSB]};
    assign auto_mode = (path_ctrl[SRC_SEL_MSB:SRC_SEL_LSB]
                        == SRC_SEL_AUTO);
    // A defect counts only when enabled and in automatic mode
    assign active = enables & defect_sync & {6{auto_mode}};

    rdi_select u_select (
        .active_i (active),
        .codes_i  (codes),
        .code_o   (chosen)
    );

    // Stream stage: one cycle delay, G1 RDI field overwritten in auto mode
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            TX_DATA_O  <= 8'h00;
            TX_G1_O    <= 1'b0;
            RDI_CODE_O <= RDI_NONE;
        end else begin
            TX_G1_O    <= TX_G1_I;
            RDI_CODE_O <= chosen;
            if (TX_G1_I && auto_mode) begin
                TX_DATA_O <= {chosen,
                    TX_DATA_I[G1_RDI_LSB-1:0]};
            end else begin
                TX_DATA_O <= TX_DATA_I;
            end
        end
    end

    // Checks
    property p_g1_field;
        @(posedge CLK_I) disable iff (!RSTN_I)
        (TX_G1_I && auto_mode) |=>
            TX_DATA_O[G1_RDI_MSB:G1_RDI_LSB] == $past(chosen);
    endproperty
    a_g1_field: assert property (p_g1_field)
        else $error("G1 RDI field not the chosen code");

    property p_other_bits;
        @(posedge CLK_I) disable iff (!RSTN_I)
        TX_G1_I |=> TX_DATA_O[G1_RDI_LSB-1:0]
                    == $past(TX_DATA_I[G1_RDI_LSB-1:0]);
    endproperty
    a_other_bits: assert property (p_other_bits)
        else $error("G1 low bits altered");

    property p_not_auto;
        @(posedge CLK_I) disable iff (!RSTN_I)
        !auto_mode |=> TX_DATA_O == $past(TX_DATA_I);
    endproperty
    a_not_auto: assert property (p_not_auto)
        else $error("Insertion outside automatic mode");

    property p_alarm_first;
        @(posedge CLK_I) disable iff (!RSTN_I)
        active[DEF_AIS] |->
            chosen == rdi_ctrl_pointer_and_alarm[LO_CODE_MSB:LO_CODE_LSB];
    endproperty
    a_alarm_first: assert property (p_alarm_first)
        else $error("Path alarm code not chosen");

    property p_pointer;
        @(posedge CLK_I) disable iff (!RSTN_I)
        (active[DEF_LOP] && !active[DEF_AIS]) |->
            chosen == rdi_ctrl_pointer_and_alarm[HI_CODE_MSB:HI_CODE_LSB];
    endproperty
    a_pointer: assert property (p_pointer)
        else $error("Pointer loss code not chosen");

    property p_uneq;
        @(posedge CLK_I) disable iff (!RSTN_I)
        (active[2:0] == 3'h4) |->
            chosen == rdi_ctrl_trace_and_unequipped[LO_CODE_MSB:LO_CODE_LSB];
    endproperty
    a_uneq: assert property (p_uneq)
        else $error("Unequipped code not chosen");

    property p_label;
        @(posedge CLK_I) disable iff (!RSTN_I)
        (active[4:0] == 5'h10) |->
            chosen == rdi_ctrl_cell_and_label[LO_CODE_MSB:LO_CODE_LSB];
    endproperty
    a_label: assert property (p_label)
        else $error("Label mismatch code not chosen");

    property p_none;
        @(posedge CLK_I) disable iff (!RSTN_I)
        (active == 6'h00) |=> RDI_CODE_O == RDI_NONE;
    endproperty
    a_none: assert property (p_none)
        else $error("Code not zero with no defect");

    sequence s_write_cell;
        WR_I && ADDR_I == ADDR_CELL_AND_LABEL;
    endsequence
    property p_write_cell;
        @(posedge CLK_I) disable iff (!RSTN_I)
        s_write_cell |=> rdi_ctrl_cell_and_label == $past(WDATA_I);
    endproperty
    a_write_cell: assert property (p_write_cell)
        else $error("Register 19C9 not written");

    property p_write_trace;
        @(posedge CLK_I) disable iff (!RSTN_I)
        (WR_I && ADDR_I == ADDR_TRACE_AND_UNEQUIPPED) |=>
            rdi_ctrl_trace_and_unequipped == $past(WDATA_I);
    endproperty
    a_write_trace: assert property (p_write_trace)
        else $error("Register 19CA not written");

    // Write followed at once by a read of the same register
    sequence s_write_ptr;
        WR_I && ADDR_I == ADDR_POINTER_AND_ALARM;
    endsequence
    sequence s_read_ptr;
        RD_I && !WR_I && ADDR_I == ADDR_POINTER_AND_ALARM;
    endsequence
    property p_write_ptr;
        @(posedge CLK_I) disable iff (!RSTN_I)
        s_write_ptr ##1 s_read_ptr |=> RDATA_O == $past(WDATA_I, 2);
    endproperty
    a_write_ptr: assert property (p_write_ptr)
        else $error("Register 19CB readback wrong");
endmodule

// file: rdi_far_end.sv
// Outbound stream source and far-end G1 capture for the RDI bench
`timescale 1ns/1ps
module rdi_far_end (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Stream towards and from the block
    output logic      [7:0] data_o,
    output logic            g1_o,
    input  wire logic [7:0] data_i,
    input  wire logic       g1_i,
    // Last G1 received and last byte sent
    output logic      [7:0] g1_seen_o,
    output logic      [7:0] sent_o
);
    logic [7:0] cnt;
    // G1 every fourth byte, fixed value so the low bits stay checkable
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt    <= 8'h00;
            data_o <= 8'h00;
            g1_o   <= 1'b0;
        end else begin
            cnt    <= cnt + 8'h01;
            g1_o   <= (cnt[1:0] == 2'h3);
            data_o <= (cnt[1:0] == 2'h3) ? 8'hB5 : cnt;
        end
    end
    // Far end keeps only the G1 it last received
    always_ff @(posedge clk_i) begin
        sent_o <= data_o;
        if (g1_i) begin
            g1_seen_o <= data_i;
        end
    end
endmodule

// file: test_tx_path_rdi_auto_insertion.sv
// Self-checking bench for the RDI-P automatic insertion block
`timescale 1ns/1ps
module test_tx_path_rdi_auto_insertion;
    import rdi_pkg::*;
    typedef struct packed {
        logic [7:0] r9;
        logic [7:0] ra;
        logic [7:0] rb;
        logic [5:0] d;
        logic [2:0] c;
    } row_s;
    logic        clk = 1'b0;
    logic        rstn, wr_en, rd_en;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, dout, din, g1_seen, sent;
    logic        g1_out, g1_in;
    logic [2:0]  code;
    logic [5:0]  defects;
    int          n_errors = 0;
    int          check_count = 0;
    // Defect bit order follows the priority indices of the package
    row_s rows[10] = '{
        '{8'h00, 8'h00, 8'h7B, 6'h01, 3'h5}, '{8'h00, 8'h00, 8'h7B, 6'h03, 3'h5},
        '{8'h00, 8'h00, 8'h7B, 6'h02, 3'h3}, '{8'h00, 8'h00, 8'h7A, 6'h03, 3'h3},
        '{8'h00, 8'hD5, 8'h00, 6'h0C, 3'h2}, '{8'h00, 8'hD4, 8'h00, 6'h0C, 3'h6},
        '{8'hF3, 8'h00, 8'h00, 6'h30, 3'h1}, '{8'hF2, 8'h00, 8'h00, 6'h30, 3'h7},
        '{8'hF3, 8'hD5, 8'h7B, 6'h00, 3'h0}, '{8'hF3, 8'hD5, 8'h7B, 6'h3F, 3'h5}};
    // 10 MHz clock
    always #50 clk = ~clk;
    tx_path_rdi_auto_insertion uut (
        .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_en), .RD_I(rd_en), .RDATA_O(rdata),
        .PATH_ALARM_I(defects[DEF_AIS]), .POINTER_LOSS_I(defects[DEF_LOP]),
        .UNEQUIPPED_I(defects[DEF_UNEQ]), .TRACE_MISMATCH_I(defects[DEF_TIM]),
        .LABEL_MISMATCH_I(defects[DEF_PLM]),
        .CELL_DELINEATION_LOSS_I(defects[DEF_LCD]),
        .TX_DATA_I(din), .TX_G1_I(g1_in), .TX_DATA_O(dout),
        .TX_G1_O(g1_out), .RDI_CODE_O(code));
    rdi_far_end far (
        .clk_i(clk), .rstn_i(rstn), .data_o(din), .g1_o(g1_in),
        .data_i(dout), .g1_i(g1_out), .g1_seen_o(g1_seen), .sent_o(sent));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) {wr_en, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr_en <= 1'b0;
    endtask
    // Read data shows in the cycle after the strobe is taken
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk) {rd_en, addr} <= {1'b1, a};
        @(posedge clk) rd_en <= 1'b0;
        @(negedge clk) check(rdata, exp);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #(3000 * 100);
        n_errors++;
        stop_test();
    end
    initial begin
        {rstn, wr_en, rd_en, addr, wdata, defects} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(ADDR_CELL_AND_LABEL, RESET_CODE_REG);
        rd(ADDR_TRACE_AND_UNEQUIPPED, RESET_CODE_REG);
        rd(ADDR_POINTER_AND_ALARM, RESET_CODE_REG);
        $display("reset values done");
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_CELL_AND_LABEL, rows[i].r9);
            wr(ADDR_TRACE_AND_UNEQUIPPED, rows[i].ra);
            wr(ADDR_POINTER_AND_ALARM, rows[i].rb);
            @(posedge clk) defects <= rows[i].d;
            repeat (9) @(posedge clk);
            @(negedge clk);
            check({5'h00, code}, {5'h00, rows[i].c});
            check(g1_seen, {rows[i].c, 5'h15});
            $display("row %0d done", i);
        end
        rd(ADDR_CELL_AND_LABEL, 8'hF3);
        rd(ADDR_TRACE_AND_UNEQUIPPED, 8'hD5);
        rd(ADDR_POINTER_AND_ALARM, 8'h7B);
        rd(16'h19CC, 8'h00);
        $display("readback done");
        // Insertion type other than 00 lets G1 through untouched;
        // pointer loss alone picks code 3, which differs from the source
        @(posedge clk) defects <= 6'h02;
        wr(ADDR_PATH_CTRL, 8'h08);
        repeat (9) @(posedge clk);
        @(negedge clk) check(g1_seen, 8'hB5);
        wr(ADDR_PATH_CTRL, 8'h00);
        repeat (9) @(posedge clk);
        @(negedge clk) check(g1_seen, 8'h75);
        while (g1_out !== 1'b0) @(negedge clk);
        check(dout, sent);
        // Write then read on the next cycle sees the new value
        @(posedge clk) begin
            {wr_en, addr, wdata} <= {1'b1, ADDR_POINTER_AND_ALARM, 8'h11};
        end
        @(posedge clk) {wr_en, rd_en} <= 2'b01;
        @(posedge clk) rd_en <= 1'b0;
        @(negedge clk) check(rdata, 8'h11);
        // Type 11: auto mode would clear the field, so G1 must stay B5
        wr(ADDR_PATH_CTRL, 8'h18);
        rd(ADDR_PATH_CTRL, 8'h18);
        repeat (9) @(posedge clk);
        @(negedge clk) check(g1_seen, 8'hB5);
        $display("insertion type done");
        // Reset in mid-run with pointer loss still declared
        @(posedge clk) rstn <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk) check({5'h00, code}, 8'h00);
        check(dout, 8'h00);
        check({7'h00, g1_out}, 8'h00);
        @(posedge clk) rstn <= 1'b1;
        rd(ADDR_POINTER_AND_ALARM, RESET_CODE_REG);
        rd(ADDR_PATH_CTRL, RESET_PATH_CTRL);
        $display("mid-run reset done");
        stop_test();
    end
endmodule
